//--- dv/adcsw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module adcsw_host_model (
    output logic sclk_o,
    output logic cs_n_o,
    output logic din_o,
    input wire logic dout_i,
    input wire logic dout_oe_i
);
    // Serial clock idles low between frames
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        din_o = 1'b0;
    end
    // One full-duplex frame, MSB first, optional pause after the first byte
    task automatic frame(input logic [15:0] tx, input int nbits, input bit split, output logic [15:0] rx);
        rx = 16'h0000;
        cs_n_o = 1'b0;
        #7.5;
        for (int k = 0; k < nbits; k++) begin
            if (split && k == 8) #60;
            din_o = tx[15-k];
            #7.5 sclk_o = 1'b1;
            #7.5 sclk_o = 1'b0;
            rx[15-k] = dout_oe_i ? dout_i : 1'bx;
        end
        #7.5;
        cs_n_o = 1'b1;
        din_o = ~din_o;
    endtask : frame
endmodule : adcsw_host_model
`default_nettype wire

//--- dv/adcsw_properties.sv
`timescale 1ns/1ps
`default_nettype none
module adcsw_properties #(
    parameter bit EOC_VARIANT = 1'b1,
    parameter int CONV_CYCLES = adcsw_pkg::CONV_CYC
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic din_i,
    input wire logic dout_o,
    input wire logic dout_oe_o,
    input wire logic conversion_clock_input_i,
    input wire logic [adcsw_pkg::RES_BITS-1:0] ain_code_i,
    input wire logic [adcsw_pkg::ADDR_BITS-1:0] chan_sel_o,
    input wire logic eoc_o,
    input wire logic busy_o,
    input wire logic addr_bad_o,
    input wire logic test_mode_o,
    input wire logic overrun_o
);
    import adcsw_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    int busy_cnt;
    // Length of the current busy interval
    always_ff @(posedge clk_i) begin
        if (srst_i || !busy_o) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= busy_cnt + 1;
        end
    end
    eoc_marks_busy_a: assert property (eoc_o == (!busy_o || !EOC_VARIANT))
        else $error("completion output disagrees with busy");
    eoc_low_width_a: assert property ($fell(eoc_o) |-> !eoc_o [*8])
        else $error("completion output low too briefly");
    busy_min_a: assert property ($fell(busy_o) |-> busy_cnt >= CONV_CYCLES)
        else $error("conversion ended early");
    busy_max_a: assert property (!EOC_VARIANT || busy_cnt <= CONV_CYCLES + 4)
        else $error("conversion ran too long");
    test_mode_code_a: assert property (busy_o && $past(busy_o) |-> test_mode_o == (chan_sel_o inside {[11:13]}))
        else $error("test flag does not match code");
    addr_bad_code_a: assert property (busy_o && $past(busy_o) |-> addr_bad_o == (chan_sel_o > 4'hD))
        else $error("bad address flag does not match code");
    chan_hold_a: assert property (busy_o && $past(busy_o) |-> $stable(chan_sel_o))
        else $error("channel changed during conversion");
    dout_idle_a: assert property (cs_n_i |-> !dout_oe_o && !dout_o)
        else $error("data out driven while deselected");
    cover property ($rose(busy_o));
    cover property (test_mode_o && $rose(eoc_o));
    cover property (addr_bad_o && $rose(eoc_o));
endmodule : adcsw_properties
bind adcsw_top adcsw_properties #(.EOC_VARIANT(EOC_VARIANT), .CONV_CYCLES(CONV_CYCLES)) u_props (
    .clk_i(clk_i), .srst_i(srst_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .din_i(din_i), .dout_o(dout_o),
    .dout_oe_o(dout_oe_o), .conversion_clock_input_i(conversion_clock_input_i), .ain_code_i(ain_code_i),
    .chan_sel_o(chan_sel_o), .eoc_o(eoc_o), .busy_o(busy_o), .addr_bad_o(addr_bad_o),
    .test_mode_o(test_mode_o), .overrun_o(overrun_o));
`default_nettype wire

//--- dv/tb_adc_serial_word_framing.sv
`timescale 1ns/1ps
`default_nettype none
module tb_adc_serial_word_framing;
    import adcsw_pkg::*;
    localparam int CONV = 40;
    logic clk_i, srst_i, conv_clk, sclk, cs_n, din, dout, dout_oe, eoc, busy, bad, tmode, ovr;
    logic [RES_BITS-1:0] ain;
    logic [ADDR_BITS-1:0] chan, code;
    logic [15:0] rx, rx_x, tx;
    logic sclk_x, cs_x, din_x, dout_x, oe_x, eoc_x, busy_x, bad_x, tmode_x, ovr_x;
    logic [ADDR_BITS-1:0] chan_x;
    int fails, n_checks, prev_exp;
    adcsw_top #(.EOC_VARIANT(1'b1), .CONV_CYCLES(CONV)) u_dut (
        .clk_i(clk_i), .srst_i(srst_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din), .dout_o(dout),
        .dout_oe_o(dout_oe), .conversion_clock_input_i(conv_clk), .ain_code_i(ain), .chan_sel_o(chan),
        .eoc_o(eoc), .busy_o(busy), .addr_bad_o(bad), .test_mode_o(tmode), .overrun_o(ovr));
    adcsw_host_model u_host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout), .dout_oe_i(dout_oe));
    // Variant timed by the conversion clock input, same stimulus
    adcsw_top #(.EOC_VARIANT(1'b0), .CONV_CYCLES(CONV)) u_dut_ext (
        .clk_i(clk_i), .srst_i(srst_i), .sclk_i(sclk_x), .cs_n_i(cs_x), .din_i(din_x), .dout_o(dout_x),
        .dout_oe_o(oe_x), .conversion_clock_input_i(conv_clk), .ain_code_i(ain), .chan_sel_o(chan_x),
        .eoc_o(eoc_x), .busy_o(busy_x), .addr_bad_o(bad_x), .test_mode_o(tmode_x), .overrun_o(ovr_x));
    adcsw_host_model u_host_ext (.sclk_o(sclk_x), .cs_n_o(cs_x), .din_o(din_x), .dout_i(dout_x), .dout_oe_i(oe_x));
    // System clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // Conversion clock input wanders at random
    always @(negedge clk_i) conv_clk <= 1'($urandom_range(0, 1));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic stop_test;
        if (fails == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test
    // Bounded wait for the completion output to fall and rise again
    task automatic wait_done;
        int n;
        n = 0;
        while (eoc !== 1'b0 && n < 20) begin
            @(negedge clk_i);
            n++;
        end
        check("eoc low", 16'(eoc), 16'h0000);
        n = 0;
        while (eoc !== 1'b1 && n < CONV + 20) begin
            @(negedge clk_i);
            n++;
        end
        check("eoc high", 16'(eoc), 16'h0001);
    endtask : wait_done
    // Every code once, then random codes; frame forms mixed
    initial begin
        void'($urandom(49));
        srst_i = 1'b1;
        conv_clk = 1'b0;
        ain = '0;
        prev_exp = 0;
        repeat (16) @(posedge clk_i);
        @(negedge clk_i) srst_i = 1'b0;
        check("eoc idle", 16'(eoc), 16'h0001);
        for (int i = 0; i < 24; i++) begin
            code = (i < 16) ? 4'(i) : 4'($urandom_range(0, 15));
            @(negedge clk_i);
            ain = 10'($urandom);
            tx = {code, 12'($urandom)};
            fork
                u_host.frame(tx, (i == 5) ? 10 : 16, i[0], rx);
                u_host_ext.frame(tx, (i == 5) ? 10 : 16, i[0], rx_x);
            join
            check("word", rx, 16'(prev_exp << 6));
            check("ext word", rx_x, 16'(prev_exp << 6));
            check("value", rx >> 6, 16'(prev_exp));
            wait_done();
            // Host counts conversion clocks, then allows for crossing latency
            repeat (EXT_CLK_COUNT) @(posedge conv_clk);
            repeat (4) @(negedge clk_i);
            check("ext busy", 16'(busy_x), 16'h0000);
            check("ext eoc", 16'(eoc_x), 16'h0001);
            prev_exp = (code <= 4'hA) ? int'(ain) : (code == 4'hB) ? 10'h200 : (code == 4'hD) ? 10'h3FF : 0;
            check("chan", 16'(chan), 16'(code));
            check("ext chan", 16'(chan_x), 16'(code));
            check("flags", 16'({tmode, bad}), 16'({code inside {[11:13]}, code > 4'hD}));
            check("ext flags", 16'({tmode_x, bad_x}), 16'({code inside {[11:13]}, code > 4'hD}));
            check("overrun", 16'({ovr_x, ovr}), 16'h0000);
        end
        stop_test();
    end
    // Watchdog
    initial begin
        #100us;
        fails++;
        stop_test();
    end
endmodule : tb_adc_serial_word_framing
`default_nettype wire

//--- verilog/adcsw_conv.sv
`timescale 1ns/1ps
`default_nettype none
module adcsw_conv #(
    parameter bit EXT_MODE = 1'b0,
    parameter int CONV_CYCLES = adcsw_pkg::CONV_CYC
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic start_i,
    input wire logic [adcsw_pkg::ADDR_BITS-1:0] code_i,
    input wire logic ext_tick_i,
    input wire logic [adcsw_pkg::RES_BITS-1:0] ain_code_i,
    output logic done_o,
    output logic [adcsw_pkg::RES_BITS-1:0] result_o
);
    import adcsw_pkg::*;

    adcsw_conv_state_t state_reg;
    adcsw_conv_state_t state_next;
    logic [CONV_CNT_BITS-1:0] cnt_reg;
    logic [CONV_CNT_BITS-1:0] cnt_next;
    logic [ADDR_BITS-1:0] code_reg;
    logic [RES_BITS-1:0] res_reg;
    logic done_reg;

    // Interval length and stepping source
    wire logic [CONV_CNT_BITS-1:0] target = EXT_MODE ? CONV_CNT_BITS'(EXT_CLK_COUNT)
                                                     : CONV_CNT_BITS'(CONV_CYCLES);
    wire logic step = EXT_MODE ? ext_tick_i : 1'b1;
    wire logic last = step && (cnt_reg == target - 1'b1);

    // Self test values replace the analog sample
    wire logic [RES_BITS-1:0] picked =
        (code_reg == CODE_HALF) ? RES_HALF :
        (code_reg == CODE_ZERO) ? RES_ZERO :
        (code_reg == CODE_FULL) ? RES_FULL :
        adcsw_code_bad(code_reg) ? RES_ZERO : ain_code_i;

    // Next state; a new start restarts the interval
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            ADCSW_IDLE: begin
                if (start_i) begin
                    state_next = ADCSW_CONVERT;
                    cnt_next = '0;
                end
            end
            ADCSW_CONVERT: begin
                if (start_i) begin
                    cnt_next = '0;
                end else if (last) begin
                    state_next = ADCSW_IDLE;
                end else if (step) begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            default: begin
                state_next = ADCSW_IDLE;
            end
        endcase
    end

    // State, code and result registers
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_reg <= ADCSW_IDLE;
            cnt_reg <= '0;
            code_reg <= ADDR_RST;
            res_reg <= RES_ZERO;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            if (start_i) begin
                code_reg <= code_i;
            end
            done_reg <= (state_reg == ADCSW_CONVERT) && !start_i && last;
            if ((state_reg == ADCSW_CONVERT) && !start_i && last) begin
                res_reg <= picked;
            end
        end
    end

    assign done_o = done_reg;
    assign result_o = res_reg;
endmodule : adcsw_conv
`default_nettype wire

//--- verilog/adcsw_pkg.sv
package adcsw_pkg;

    // Word layout
    localparam int WORD_BITS = 16;
    localparam int RES_BITS = 10;
    localparam int ADDR_BITS = 4;
    localparam int PAD_BITS = 6;
    localparam int CNT_BITS = 5;
    localparam int CONV_CNT_BITS = 14;

    // Serial edge positions
    localparam logic [CNT_BITS-1:0] ADDR_EDGES = 5'h04;
    localparam logic [CNT_BITS-1:0] START_FALL = 5'h0A;
    localparam logic [CNT_BITS-1:0] WORD_EDGES = 5'h10;

    // Conversion timing
    localparam int EXT_CLK_COUNT = 44;
    localparam int CONV_TIME_NS = 44000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int CONV_CYC = CONV_TIME_NS / CLK_PERIOD_NS;

    // Channel and test codes
    localparam logic [ADDR_BITS-1:0] CODE_LAST_INPUT = 4'hA;
    localparam logic [ADDR_BITS-1:0] CODE_HALF = 4'hB;
    localparam logic [ADDR_BITS-1:0] CODE_ZERO = 4'hC;
    localparam logic [ADDR_BITS-1:0] CODE_FULL = 4'hD;
    localparam logic [RES_BITS-1:0] RES_HALF = 10'h200;
    localparam logic [RES_BITS-1:0] RES_ZERO = 10'h000;
    localparam logic [RES_BITS-1:0] RES_FULL = 10'h3FF;

    // Values after reset
    localparam logic [ADDR_BITS-1:0] ADDR_RST = 4'h0;
    localparam logic [WORD_BITS-1:0] WORD_RST = 16'h0000;

    typedef enum logic {
        ADCSW_IDLE,
        ADCSW_CONVERT
    } adcsw_conv_state_t;

    // Left justify a result into the output word
    function automatic logic [WORD_BITS-1:0] adcsw_justify(input logic [RES_BITS-1:0] res);
        adcsw_justify = {res, {PAD_BITS{1'b0}}};
    endfunction : adcsw_justify

    // Codes that no host may send
    function automatic logic adcsw_code_bad(input logic [ADDR_BITS-1:0] code);
        adcsw_code_bad = (code > CODE_FULL);
    endfunction : adcsw_code_bad

    // Internal test codes
    function automatic logic adcsw_code_test(input logic [ADDR_BITS-1:0] code);
        adcsw_code_test = (code > CODE_LAST_INPUT) && !adcsw_code_bad(code);
    endfunction : adcsw_code_test

endpackage : adcsw_pkg

//--- verilog/adcsw_top.sv
`timescale 1ns/1ps
`default_nettype none
module adcsw_top #(
    parameter bit EOC_VARIANT = 1'b1,
    parameter int CONV_CYCLES = adcsw_pkg::CONV_CYC
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic din_i,
    output logic dout_o,
    output logic dout_oe_o,
    input wire logic conversion_clock_input_i,
    input wire logic [adcsw_pkg::RES_BITS-1:0] ain_code_i,
    output logic [adcsw_pkg::ADDR_BITS-1:0] chan_sel_o,
    output logic eoc_o,
    output logic busy_o,
    output logic addr_bad_o,
    output logic test_mode_o,
    output logic overrun_o
);
    import adcsw_pkg::*;

    // ---------------- Link domain (serial clock) ----------------

    logic [CNT_BITS-1:0] rise_cnt_reg;
    logic [CNT_BITS-1:0] fall_cnt_reg;
    logic [ADDR_BITS-1:0] addr_shift_reg;
    logic [ADDR_BITS-1:0] addr_xfer_reg;
    logic start_tgl_reg;
    logic dout_reg;
    logic dout_oe_reg;

    // ---------------- System domain ----------------

    logic tgl_s1_reg;
    logic tgl_s2_reg;
    logic tgl_s3_reg;
    logic ext_s1_reg;
    logic ext_s2_reg;
    logic ext_s3_reg;
    logic [WORD_BITS-1:0] word_reg;
    logic [ADDR_BITS-1:0] chan_sel_reg;
    logic eoc_reg;
    logic busy_reg;
    logic addr_bad_reg;
    logic test_mode_reg;
    logic overrun_reg;
    logic conv_done;
    logic [RES_BITS-1:0] conv_result;

    // Output bit for the coming rising edge, zero past the word
    wire logic [CNT_BITS-1:0] bit_pos = WORD_EDGES - 1'b1 - rise_cnt_reg;
    wire logic word_left = (rise_cnt_reg < WORD_EDGES);
    wire logic out_bit = word_left ? word_reg[bit_pos[3:0]] : 1'b0;
    wire logic addr_phase = (rise_cnt_reg < ADDR_EDGES);
    wire logic start_fall = (fall_cnt_reg == START_FALL - 1'b1);

    // Rising edges: shift address in and result out together
    always_ff @(posedge sclk_i or posedge cs_n_i or posedge srst_i) begin
        if (cs_n_i || srst_i) begin
            rise_cnt_reg <= '0;
            addr_shift_reg <= ADDR_RST;
            dout_reg <= 1'b0;
            dout_oe_reg <= 1'b0;
        end else begin
            if (word_left) begin
                rise_cnt_reg <= rise_cnt_reg + 1'b1;
            end
            if (addr_phase) begin
                addr_shift_reg <= {addr_shift_reg[ADDR_BITS-2:0], din_i};
            end
            dout_reg <= out_bit;
            dout_oe_reg <= 1'b1;
        end
    end

    // Falling edges counted within the frame
    always_ff @(negedge sclk_i or posedge cs_n_i or posedge srst_i) begin
        if (cs_n_i || srst_i) begin
            fall_cnt_reg <= '0;
        end else if (fall_cnt_reg < WORD_EDGES) begin
            fall_cnt_reg <= fall_cnt_reg + 1'b1;
        end
    end

    // Tenth falling edge launches the conversion
    always_ff @(negedge sclk_i or posedge srst_i) begin
        if (srst_i) begin
            start_tgl_reg <= 1'b0;
            addr_xfer_reg <= ADDR_RST;
        end else if (!cs_n_i && start_fall) begin
            start_tgl_reg <= ~start_tgl_reg;
            addr_xfer_reg <= addr_shift_reg;
        end
    end

    // ---------------- Crossing into the system clock ----------------

    // Start toggle and conversion clock pass three flip-flops
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tgl_s1_reg <= 1'b0;
            tgl_s2_reg <= 1'b0;
            tgl_s3_reg <= 1'b0;
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
            ext_s3_reg <= 1'b0;
        end else begin
            tgl_s1_reg <= start_tgl_reg;
            tgl_s2_reg <= tgl_s1_reg;
            tgl_s3_reg <= tgl_s2_reg;
            ext_s1_reg <= conversion_clock_input_i;
            ext_s2_reg <= ext_s1_reg;
            ext_s3_reg <= ext_s2_reg;
        end
    end

    // Start event; address held stable since the toggle
    wire logic start_evt = tgl_s2_reg ^ tgl_s3_reg;
    wire logic ext_tick = ext_s2_reg && !ext_s3_reg;
    wire logic [ADDR_BITS-1:0] start_code = addr_xfer_reg;

    // Timed conversion engine
    adcsw_conv #(
        .EXT_MODE(!EOC_VARIANT),
        .CONV_CYCLES(CONV_CYCLES)
    ) u_conv (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .start_i(start_evt),
        .code_i(start_code),
        .ext_tick_i(ext_tick),
        .ain_code_i(ain_code_i),
        .done_o(conv_done),
        .result_o(conv_result)
    );

    // Completion output: low at start, high when result ready; held high when EOC_VARIANT is clear
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            eoc_reg <= 1'b1;
        end else if (!EOC_VARIANT) begin
            eoc_reg <= 1'b1;
        end else if (start_evt) begin
            eoc_reg <= 1'b0;
        end else if (conv_done) begin
            eoc_reg <= 1'b1;
        end
    end

    // Result word for the next exchange
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            word_reg <= WORD_RST;
        end else if (conv_done) begin
            word_reg <= adcsw_justify(conv_result);
        end
    end

    // Channel select and code status, taken at start
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            chan_sel_reg <= ADDR_RST;
            addr_bad_reg <= 1'b0;
            test_mode_reg <= 1'b0;
        end else if (start_evt) begin
            chan_sel_reg <= start_code;
            addr_bad_reg <= adcsw_code_bad(start_code);
            test_mode_reg <= adcsw_code_test(start_code);
        end
    end

    // Busy and restart while busy
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            busy_reg <= 1'b0;
            overrun_reg <= 1'b0;
        end else begin
            if (start_evt) begin
                busy_reg <= 1'b1;
                overrun_reg <= busy_reg;
            end else if (conv_done) begin
                busy_reg <= 1'b0;
            end
        end
    end

    // Output drive
    assign dout_o = dout_reg;
    assign dout_oe_o = dout_oe_reg;
    assign chan_sel_o = chan_sel_reg;
    assign eoc_o = eoc_reg;
    assign busy_o = busy_reg;
    assign addr_bad_o = addr_bad_reg;
    assign test_mode_o = test_mode_reg;
    assign overrun_o = overrun_reg;
endmodule : adcsw_top
`default_nettype wire
